// [bench/spc_chk_asserts.sv]
// Purpose: port checks of the synth config/status block
// Assumes: zero wait APB, single pclk domain
// Notes:   bound onto spc_top below
`timescale 1ns/1ps
module spc_chk
    import spc_pkg::*;
#(
    parameter int unsigned LOCK_DWELL = LOCK_CYC
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        crystal_present,
    input spc_cfg_t         synth_cfg,
    input spc_freq_t        xtal_freq,
    input wire logic        fod_src_synth,
    input wire logic        int_clk_ready
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_acc;
        psel && penable && pready;
    endsequence
    sequence s_wr(logic [7:0] a);
        s_acc ##0 pwrite && pstrb == 4'hf && paddr == a;
    endsequence

    property p_err_phase; pslverr |-> psel && penable; endproperty
    a_err_phase: assert property (p_err_phase) else $error("slverr outside access");
    property p_fod; fod_src_synth; endproperty
    a_fod: assert property (p_fod) else $error("fod source not synth");
    property p_div_range; synth_cfg.fb_div >= 10'h06c && synth_cfg.fb_div <= 10'h22c; endproperty
    a_div_range: assert property (p_div_range) else $error("divider out of range");
    property p_ctrl_ok;
        s_wr(OFF_CTRL) ##0 !pslverr |=> synth_cfg == {$past(pwdata[0]), $past(pwdata[25:16])};
    endproperty
    a_ctrl_ok: assert property (p_ctrl_ok) else $error("ctrl write lost");
    property p_ctrl_bad; s_acc ##0 pwrite && paddr == OFF_CTRL && pslverr |=> $stable(synth_cfg);
    endproperty
    a_ctrl_bad: assert property (p_ctrl_bad) else $error("refused write changed cfg");
    property p_unmapped; s_acc ##0 paddr > OFF_FM_HI |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_fm_lo; s_wr(OFF_FM_LO) |=> xtal_freq.num[31:0] == $past(pwdata); endproperty
    a_fm_lo: assert property (p_fm_lo) else $error("numerator low word");
    property p_fm_hi;
        s_wr(OFF_FM_HI) |=> xtal_freq.den == $past(pwdata[31:16])
            && xtal_freq.num[47:32] == $past(pwdata[15:0]);
    endproperty
    a_fm_hi: assert property (p_fm_hi) else $error("numerator high or denominator");
    property p_xtal_loss; !crystal_present [*5] |-> !int_clk_ready; endproperty
    a_xtal_loss: assert property (p_xtal_loss) else $error("clocks without crystal");
    property p_relock; s_wr(OFF_CTRL) ##0 !pslverr |-> ##3 !int_clk_ready; endproperty
    a_relock: assert property (p_relock) else $error("lock kept over new cfg");
endmodule

bind spc_top spc_chk #(.LOCK_DWELL(LOCK_DWELL)) spc_chk_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .crystal_present(crystal_present), .synth_cfg(synth_cfg), .xtal_freq(xtal_freq),
    .fod_src_synth(fod_src_synth), .int_clk_ready(int_clk_ready));

// [bench/spc_core_model.sv]
// Purpose: analog core stand-in producing the loop filter code
// Assumes: lock window edges as configured by synth_cfg
// Notes:   code is set at or just past an edge to probe inclusivity
`timescale 1ns/1ps
module spc_core_model
    import spc_pkg::*;
(
    input  wire logic       pclk,
    input  spc_cfg_t        synth_cfg,
    input  wire logic [1:0] mode,
    output logic      [7:0] vctrl_code
);
    logic [7:0] lo_w;
    logic [7:0] hi_w;

    // limits follow the divider and doubler, no threshold input
    assign lo_w = 8'h30 + {3'h0, synth_cfg.fb_div[9:5]} + (synth_cfg.doubler_en ? 8'h08 : 8'h00);
    assign hi_w = 8'hd0 - {3'h0, synth_cfg.fb_div[9:5]} - (synth_cfg.doubler_en ? 8'h08 : 8'h00);

    // one cycle of lag, as a real loop filter never answers at once
    always_ff @(posedge pclk) begin
        case (mode)
            2'h0: vctrl_code <= lo_w - 8'h01;
            2'h1: vctrl_code <= lo_w;
            2'h2: vctrl_code <= hi_w;
            default: vctrl_code <= hi_w + 8'h01;
        endcase
    end
endmodule

// [bench/tb.sv]
// Purpose: register level test of the synth config/status block
// Assumes: zero wait APB slave, short lock dwell
// Notes:   straps held steady apart from one crystal_present drop, reset reapplied to change load source
`timescale 1ns/1ps
module tb;
    import spc_pkg::*;
    localparam spc_cfg_t OTP_IMG = {1'b1, 10'h110};
    localparam spc_cfg_t EE_IMG  = {1'b0, 10'h21c};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, vctrl_code;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        otp_enable, otp_valid, eeprom_enable, eeprom_valid, crystal_present;
    spc_cfg_t    otp_cfg, eeprom_cfg, synth_cfg, exp_cfg;
    spc_freq_t   xtal_freq;
    logic [1:0]  mode;
    logic        fod_src_synth, int_clk_ready, gpio_alarm, irq;
    logic [9:0]  divs [4] = '{10'h06b, 10'h06c, 10'h22c, 10'h22d};
    int          miscompares, n_compared;

    spc_top #(.LOCK_DWELL(4)) spc_top_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .otp_enable(otp_enable), .otp_valid(otp_valid), .otp_cfg(otp_cfg),
        .eeprom_enable(eeprom_enable), .eeprom_valid(eeprom_valid), .eeprom_cfg(eeprom_cfg),
        .crystal_present(crystal_present), .vctrl_code(vctrl_code), .synth_cfg(synth_cfg),
        .xtal_freq(xtal_freq), .fod_src_synth(fod_src_synth), .int_clk_ready(int_clk_ready),
        .gpio_alarm(gpio_alarm), .irq(irq));
    spc_core_model spc_core_model_i (
        .pclk(pclk), .synth_cfg(synth_cfg), .mode(mode), .vctrl_code(vctrl_code));

    always #2.5 pclk = ~pclk;

    task automatic end_of_test;
        if (miscompares == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'hf);
        int i;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            miscompares++;
            end_of_test;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask

    // polls status; a bit that never comes ends the run
    task automatic wait_stat(int b);
        int i;
        for (i = 0; i < 60; i++) begin
            apb(1'b0, OFF_STAT, 32'h0);
            if (rd[b] === 1'b1) break;
        end
        if (i == 60) begin
            miscompares++;
            end_of_test;
        end
    endtask

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        pstrb = 0; otp_enable = 1; otp_valid = 1; eeprom_enable = 1; eeprom_valid = 1;
        otp_cfg = OTP_IMG; eeprom_cfg = EE_IMG; crystal_present = 1; mode = 2'h1;
        miscompares = 0; n_compared = 0;
        // both images land inside the synth tuning range
        do_reset;
        chk("xtal_rst", {XTAL_NUM_RST, XTAL_DEN_RST}, xtal_freq);
        apb(1'b1, OFF_CTRL, 32'h0110_0001);
        chk("early_ctrl_err", 1, err);
        wait_stat(STAT_LOADED_BIT);
        chk("otp_load", OTP_IMG, synth_cfg);
        chk("otp_src", 2'h1, rd[5:4]);
        wait_stat(STAT_LOCK_BIT);
        chk("clk_ready", 1, int_clk_ready);
        chk("fod_src", 1, fod_src_synth);
        apb(1'b1, OFF_GPIO, 32'h1);
        @(posedge pclk);
        chk("gpio_quiet", 0, gpio_alarm);
        mode <= 2'h3;
        wait_stat(STAT_LOL_BIT);
        chk("gpio_alarm", 1, gpio_alarm);
        apb(1'b0, OFF_ISTAT, 32'h0);
        chk("lol_event", 1, rd[EV_LOL]);
        mode <= 2'h2;
        wait_stat(STAT_LOCK_BIT);
        apb(1'b1, OFF_GPIO, 32'h3);
        @(posedge pclk);
        chk("gpio_inv", 1, gpio_alarm);
        exp_cfg = OTP_IMG;
        foreach (divs[i]) begin
            apb(1'b1, OFF_CTRL, {6'h0, divs[i], 15'h0, i[0]});
            chk("div_err", i == 0 || i == 3, err);
            if (i == 1 || i == 2) exp_cfg = {i[0], divs[i]};
            chk("div_cfg", exp_cfg, synth_cfg);
        end
        apb(1'b1, OFF_IMASK, 32'h4);
        @(posedge pclk);
        chk("irq_set", 1, irq);
        apb(1'b1, OFF_ISTAT, 32'h4);
        @(posedge pclk);
        chk("irq_clr", 0, irq);
        crystal_present <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("xtal_lost", 0, int_clk_ready);
        crystal_present <= 1'b1;
        apb(1'b1, OFF_FM_LO, 32'h60b9_924d);
        apb(1'b1, OFF_FM_HI, 32'h009e_0006);
        chk("ratio", {48'h0006_60b9_924d, 16'h009e}, xtal_freq);
        apb(1'b0, OFF_FM_HI, 32'h0);
        chk("ratio_rd", 32'h009e_0006, rd);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", {1'b1, 32'h0}, {err, rd});
        otp_valid <= 1'b0;
        do_reset;
        wait_stat(STAT_LOADED_BIT);
        chk("ee_load", EE_IMG, synth_cfg);
        chk("ee_src", 2'h2, rd[5:4]);
        end_of_test;
    end
endmodule

// [verilog/spc_lock_det.sv]
// Purpose: lock detector on the loop filter control voltage code
// Assumes: vctrl already synchronised
// Notes:   any excursion drops lock at once; reacquire needs a full dwell
`timescale 1ns/1ps
module spc_lock_det
    import spc_pkg::*;
#(
    parameter int unsigned DWELL = LOCK_CYC
) (
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire logic [7:0] vctrl,
    input  spc_cfg_t      cfg,
    input  wire logic     arm,
    input  wire logic     restart,
    output logic          locked
);
    if (DWELL < 1 || DWELL > 4096) begin : g_chk
        $error("spc_lock_det DWELL out of range");
    end

    localparam int unsigned CW = $clog2(DWELL + 1);
    localparam logic [CW-1:0] DWELL_LAST = CW'(DWELL - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          locked;
    } spc_ld_t;

    spc_ld_t  st_reg;
    spc_ld_t  st_next;
    spc_win_t win;
    logic     in_win;

    always_comb begin
        win     = spc_lock_win(cfg);
        in_win  = (vctrl >= win.lo) && (vctrl <= win.hi);
        st_next = st_reg;
        if (!arm || restart || !in_win) begin
            st_next.cnt    = '0;
            st_next.locked = 1'b0;
        end else if (st_reg.cnt == DWELL_LAST) begin
            st_next.locked = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + CW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign locked = st_reg.locked;
endmodule

// [verilog/spc_pkg.sv]
// Purpose: shared constants, types and helpers for the synth config/status block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   all timing counts derive from the 200 MHz pclk
package spc_pkg;

    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned SETTLE_NS     = 50;
    localparam int unsigned SETTLE_CYC    = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned LOCK_NS       = 1000;
    localparam int unsigned LOCK_CYC      = (LOCK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_STAT  = 8'h04;
    localparam logic [7:0] OFF_ISTAT = 8'h08;
    localparam logic [7:0] OFF_IMASK = 8'h0c;
    localparam logic [7:0] OFF_GPIO  = 8'h10;
    localparam logic [7:0] OFF_FM_LO = 8'h14;
    localparam logic [7:0] OFF_FM_HI = 8'h18;

    localparam int unsigned FB_DIV_W     = 10;
    localparam int unsigned CTRL_DBL_BIT = 0;
    localparam int unsigned CTRL_DIV_LSB = 16;
    localparam logic [FB_DIV_W-1:0] FB_DIV_MIN = 10'h06c;
    localparam logic [FB_DIV_W-1:0] FB_DIV_MAX = 10'h22c;
    localparam logic [FB_DIV_W-1:0] FB_DIV_RST = 10'h1b0;
    localparam logic                DBL_RST    = 1'b0;

    localparam int unsigned STAT_LOCK_BIT   = 0;
    localparam int unsigned STAT_LOL_BIT    = 1;
    localparam int unsigned STAT_LOADED_BIT = 2;
    localparam int unsigned STAT_XTAL_BIT   = 3;
    localparam int unsigned STAT_SRC_LSB    = 4;

    localparam int unsigned EV_W       = 4;
    localparam int unsigned EV_LOL     = 0;
    localparam int unsigned EV_LOCK    = 1;
    localparam int unsigned EV_CFGERR  = 2;
    localparam int unsigned EV_LOADED  = 3;
    localparam logic [EV_W-1:0] IMASK_RST = 4'h0;

    localparam int unsigned GPIO_EN_BIT  = 0;
    localparam int unsigned GPIO_INV_BIT = 1;

    localparam int unsigned NUM_W = 48;
    localparam int unsigned DEN_W = 16;
    localparam logic [NUM_W-1:0] XTAL_NUM_RST = 48'h0000_017d_7840;
    localparam logic [DEN_W-1:0] XTAL_DEN_RST = 16'h0001;

    typedef struct packed {
        logic                doubler_en;
        logic [FB_DIV_W-1:0] fb_div;
    } spc_cfg_t;

    typedef struct packed {
        logic [NUM_W-1:0] num;
        logic [DEN_W-1:0] den;
    } spc_freq_t;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
    } spc_win_t;

    typedef enum logic [1:0] {
        SRC_NONE   = 2'b00,
        SRC_OTP    = 2'b01,
        SRC_EEPROM = 2'b10
    } spc_src_t;

    typedef enum logic [1:0] {
        LD_WAIT = 2'b00,
        LD_PICK = 2'b01,
        LD_DONE = 2'b10
    } spc_load_t;

    function automatic logic spc_div_ok(input logic [FB_DIV_W-1:0] d);
        return (d >= FB_DIV_MIN) && (d <= FB_DIV_MAX);
    endfunction

    function automatic logic [31:0] spc_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // window narrows as the divider grows and when the doubler runs
    function automatic spc_win_t spc_lock_win(input spc_cfg_t c);
        spc_win_t w;
        w.lo = 8'h30 + {3'h0, c.fb_div[9:5]} + (c.doubler_en ? 8'h08 : 8'h00);
        w.hi = 8'hd0 - {3'h0, c.fb_div[9:5]} - (c.doubler_en ? 8'h08 : 8'h00);
        return w;
    endfunction

endpackage

// [verilog/spc_sync2.sv]
// Purpose: two-flop synchroniser for pins from outside the pclk domain
// Assumes: each bit is a slow level; multi-bit codes may show a mixed value for one cycle
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module spc_sync2
    import spc_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    if (W < 1) begin : g_chk
        $error("spc_sync2 needs W of at least 1");
    end

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } spc_sync_t;

    spc_sync_t st_reg;
    spc_sync_t st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;
endmodule

// [verilog/spc_top.sv]
// Purpose: configuration, loading and lock status of the system synth module
// Assumes: APB slave, zero wait states; analog core, OTP and EEPROM readers outside
// Notes:   vctrl code and all straps arrive asynchronously and are synchronised here
`timescale 1ns/1ps

module spc_top
    import spc_pkg::*;
#(
    parameter int unsigned LOCK_DWELL = LOCK_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        otp_enable,
    input  wire logic        otp_valid,
    input  spc_cfg_t         otp_cfg,
    input  wire logic        eeprom_enable,
    input  wire logic        eeprom_valid,
    input  spc_cfg_t         eeprom_cfg,
    input  wire logic        crystal_present,
    input  wire logic [7:0]  vctrl_code,
    output spc_cfg_t         synth_cfg,
    output spc_freq_t        xtal_freq,
    output logic             fod_src_synth,
    output logic             int_clk_ready,
    output logic             gpio_alarm,
    output logic             irq
);
    if (LOCK_DWELL < 1 || LOCK_DWELL > 4096) begin : g_chk
        $error("spc_top LOCK_DWELL out of range");
    end

    localparam int unsigned SW = $clog2(SETTLE_CYC + 1);
    localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYC - 1);
    localparam int unsigned CFG_W = $bits(spc_cfg_t);
    localparam int unsigned PIN_W = 2 * CFG_W + 13;

    typedef struct packed {
        spc_load_t       ld;
        logic [SW-1:0]   cnt;
        spc_src_t        src;
        spc_cfg_t        cfg;
        spc_freq_t       freq;
        logic [EV_W-1:0] istat;
        logic [EV_W-1:0] imask;
        logic [1:0]      gpio_cfg;
        logic            restart;
        logic            locked_d;
        logic            gpio_q;
        logic            clk_rdy;
        logic            irq_q;
        logic [31:0]     rdata;
    } spc_state_t;

    spc_state_t      st_reg;
    spc_state_t      st_next;
    logic [PIN_W-1:0] pins_async;
    logic [PIN_W-1:0] pins;
    logic            s_otp_en;
    logic            s_otp_ok;
    spc_cfg_t        s_otp_cfg;
    logic            s_ee_en;
    logic            s_ee_ok;
    spc_cfg_t        s_ee_cfg;
    logic            s_xtal;
    logic [7:0]      s_vctrl;
    logic            locked;
    logic            loaded;
    logic            alarm;
    logic            acc;
    logic            acc_w;
    logic            mapped;
    logic            bad;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] w1c;
    logic [31:0]     wv;

    function automatic logic [31:0] ctrl_word(input spc_cfg_t c);
        return (32'(c.fb_div) << CTRL_DIV_LSB) | (32'(c.doubler_en) << CTRL_DBL_BIT);
    endfunction

    assign pins_async = {otp_enable, otp_valid, otp_cfg, eeprom_enable, eeprom_valid,
                         eeprom_cfg, crystal_present, vctrl_code};

    spc_sync2 #(
        .W (PIN_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pins_async),
        .q       (pins)
    );

    assign {s_otp_en, s_otp_ok, s_otp_cfg, s_ee_en, s_ee_ok, s_ee_cfg, s_xtal, s_vctrl} = pins;
    assign loaded = (st_reg.ld == LD_DONE);

    spc_lock_det #(
        .DWELL (LOCK_DWELL)
    ) u_lock (
        .pclk    (pclk),
        .presetn (presetn),
        .vctrl   (s_vctrl),
        .cfg     (st_reg.cfg),
        .arm     (loaded & s_xtal),
        .restart (st_reg.restart),
        .locked  (locked)
    );

    // alarm stands whenever a loaded synth is not locked
    assign alarm  = loaded & ~locked;
    assign acc    = psel & penable;
    assign acc_w  = acc & pwrite;
    assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_STAT) || (paddr == OFF_ISTAT) ||
                    (paddr == OFF_IMASK) || (paddr == OFF_GPIO) || (paddr == OFF_FM_LO) ||
                    (paddr == OFF_FM_HI);

    always_comb begin
        st_next         = st_reg;
        st_next.restart = 1'b0;
        ev              = '0;
        w1c             = '0;
        bad             = acc & ~mapped;
        wv              = spc_merge(ctrl_word(st_reg.cfg), pwdata, pstrb);

        unique case (st_reg.ld)
            LD_WAIT: begin
                // straps need the synchroniser plus settle time before they are trusted
                if (st_reg.cnt == SETTLE_LAST) begin
                    st_next.ld = LD_PICK;
                end else begin
                    st_next.cnt = st_reg.cnt + SW'(1);
                end
            end
            LD_PICK: begin
                st_next.ld      = LD_DONE;
                st_next.restart = 1'b1;
                ev[EV_LOADED]   = 1'b1;
                if (s_otp_en && s_otp_ok) begin
                    st_next.src = SRC_OTP;
                    st_next.cfg = s_otp_cfg;
                end else if (s_ee_en && s_ee_ok) begin
                    st_next.src = SRC_EEPROM;
                    st_next.cfg = s_ee_cfg;
                end
                // an image with an illegal divider keeps the reset default
                if (st_next.src != SRC_NONE && !spc_div_ok(st_next.cfg.fb_div)) begin
                    st_next.cfg   = st_reg.cfg;
                    ev[EV_CFGERR] = 1'b1;
                end
            end
            LD_DONE: begin
            end
            default: begin
                st_next.ld = LD_WAIT;
            end
        endcase

        if (acc_w) begin
            unique case (paddr)
                OFF_CTRL: begin
                    if (!loaded) begin
                        bad = 1'b1;
                    end else if (!spc_div_ok(wv[CTRL_DIV_LSB +: FB_DIV_W])) begin
                        bad           = 1'b1;
                        ev[EV_CFGERR] = 1'b1;
                    end else begin
                        // no range check on the product; software owns
                        st_next.cfg.fb_div     = wv[CTRL_DIV_LSB +: FB_DIV_W];
                        st_next.cfg.doubler_en = wv[CTRL_DBL_BIT];
                        st_next.restart        = 1'b1;
                    end
                end
                OFF_ISTAT: begin
                    w1c = EV_W'(spc_merge(32'h0, pwdata, pstrb));
                end
                OFF_IMASK: begin
                    st_next.imask = EV_W'(spc_merge(32'(st_reg.imask), pwdata, pstrb));
                end
                OFF_GPIO: begin
                    st_next.gpio_cfg = 2'(spc_merge(32'(st_reg.gpio_cfg), pwdata, pstrb));
                end
                OFF_FM_LO: begin
                    st_next.freq.num[31:0] = spc_merge(st_reg.freq.num[31:0],
                                                       pwdata, pstrb);
                end
                OFF_FM_HI: begin
                    wv = spc_merge({st_reg.freq.den, st_reg.freq.num[47:32]}, pwdata, pstrb);
                    st_next.freq.num[47:32] = wv[15:0];
                    st_next.freq.den        = wv[31:16];
                end
                default: begin
                end
            endcase
        end

        st_next.locked_d = locked;
        ev[EV_LOL]       = st_reg.locked_d & ~locked;
        ev[EV_LOCK]      = ~st_reg.locked_d & locked;
        // a new event beats a same-cycle clear
        st_next.istat    = (st_reg.istat & ~w1c) | ev;
        st_next.irq_q    = |(st_next.istat & st_next.imask);

        if (psel && !penable) begin
            unique case (paddr)
                OFF_CTRL:  st_next.rdata = ctrl_word(st_reg.cfg);
                OFF_STAT:  st_next.rdata = (32'(locked) << STAT_LOCK_BIT) |
                                           (32'(alarm) << STAT_LOL_BIT) |
                                           (32'(loaded) << STAT_LOADED_BIT) |
                                           (32'(s_xtal) << STAT_XTAL_BIT) |
                                           (32'(st_reg.src) << STAT_SRC_LSB);
                OFF_ISTAT: st_next.rdata = 32'(st_reg.istat);
                OFF_IMASK: st_next.rdata = 32'(st_reg.imask);
                OFF_GPIO:  st_next.rdata = 32'(st_reg.gpio_cfg);
                OFF_FM_LO: st_next.rdata = st_reg.freq.num[31:0];
                OFF_FM_HI: st_next.rdata = {st_reg.freq.den, st_reg.freq.num[47:32]};
                default:   st_next.rdata = 32'h0;
            endcase
        end

        st_next.gpio_q  = st_reg.gpio_cfg[GPIO_EN_BIT] &
                          (alarm ^ st_reg.gpio_cfg[GPIO_INV_BIT]);
        st_next.clk_rdy = locked & s_xtal;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg                 <= '0;
            st_reg.ld              <= LD_WAIT;
            st_reg.src             <= SRC_NONE;
            st_reg.cfg.fb_div      <= FB_DIV_RST;
            st_reg.cfg.doubler_en  <= DBL_RST;
            st_reg.freq.num        <= XTAL_NUM_RST;
            st_reg.freq.den        <= XTAL_DEN_RST;
            st_reg.imask           <= IMASK_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata        = st_reg.rdata;
    assign pready        = 1'b1;
    assign pslverr       = bad;
    assign synth_cfg     = st_reg.cfg;
    assign xtal_freq     = st_reg.freq;
    assign fod_src_synth = 1'b1;
    assign int_clk_ready = st_reg.clk_rdy;
    assign gpio_alarm    = st_reg.gpio_q;
    assign irq           = st_reg.irq_q;
endmodule
